// ### design/clk_pm_pkg.sv
package clk_pm_pkg;
   localparam int unsigned PER_N = 4;
   localparam int unsigned WAKE_W = 12;
   localparam int unsigned DIV_W = 5;
   localparam logic [7:0] SRC_SEL_OFS = 8'h00;
   localparam logic [7:0] PLL_CTRL_OFS = 8'h04;
   localparam logic [7:0] DIV_CTRL_OFS = 8'h08;
   localparam logic [7:0] PER_DIV_OFS = 8'h0C;
   localparam logic [7:0] PER_GATE_OFS = 8'h10;
   localparam logic [7:0] OSC_CTRL_OFS = 8'h14;
   localparam logic [7:0] PWR_CTRL_OFS = 8'h18;
   localparam logic [7:0] STATUS_OFS = 8'h1C;
   localparam logic [3:0] IDX_SRC = 4'h0;
   localparam logic [3:0] IDX_PLL = 4'h1;
   localparam logic [3:0] IDX_DIV = 4'h2;
   localparam logic [3:0] IDX_PDIV = 4'h3;
   localparam logic [3:0] IDX_GATE = 4'h4;
   localparam logic [3:0] IDX_OSC = 4'h5;
   localparam logic [3:0] IDX_PWR = 4'h6;
   localparam logic [3:0] IDX_STAT = 4'h7;
   localparam logic [3:0] IDX_NONE = 4'h8;
   localparam int unsigned OSC_EN_BIT = 0;
   localparam int unsigned PWR_SLEEP_BIT = 0;
   localparam int unsigned PWR_DEEP_BIT = 1;
   localparam int unsigned WAKE_POS = 16;
   localparam logic [1:0] OUT_CPU = 2'h0;
   localparam logic [1:0] OUT_OSC = 2'h1;
   localparam logic [1:0] OUT_RTC = 2'h2;
   localparam logic [1:0] OUT_WDT = 2'h3;
   localparam logic [4:0] SRC_SEL_RST = 5'h00;
   localparam logic [10:0] PLL_CTRL_RST = 11'h000;
   localparam logic [12:0] DIV_CTRL_RST = 13'h0000;
   localparam logic [PER_N-1:0] PER_GATE_RST = 4'hF;
   localparam logic [4:0] PLL_DIV_MIN = 5'h02;
   localparam logic [12:0] IRC_STALL_CYC = 13'h0004;
   localparam logic [12:0] OSC_STALL_CYC = 13'h1000;
   localparam int unsigned RTC_TICKS_DEF = 32768;
   localparam int unsigned OSC_STARTUP_DEF = 4096;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_SLEEP = 2'b01,
      ST_DEEP = 2'b10,
      ST_STALL = 2'b11
   } pm_state_type;

   typedef struct packed {
      logic usb_alt;
      logic [1:0] out_sel;
      logic cpu_pll;
      logic ref_osc;
   } src_sel_type;

   typedef struct packed {
      logic [3:0] alt_div;
      logic [3:0] main_div;
      logic alt_en;
      logic main_conn;
      logic main_en;
   } pll_ctrl_type;

   typedef struct packed {
      logic [3:0] out_div;
      logic [3:0] usb_div;
      logic [4:0] cpu_div;
   } div_ctrl_type;

   typedef struct packed {
      logic pulse;
      logic [4:0] cnt;
   } div_step_type;
endpackage : clk_pm_pkg

// ### design/clock_power_mode_control.sv
// Contract
// - Main PLL reference is the RC oscillator or main oscillator, by select.
// - Alternate PLL runs from the main oscillator only.
// - Both PLLs are off and unpowered after reset until software enables.
// - Core clock equals the PLL reference unless main PLL on and connected.
// - PLL output dividers never go below two.
// - USB clock may use the main PLL route when alternate PLL is off.
// - Each generated clock picks its source by select, then divides.
// - Every peripheral has its own divider and a gate removing its clock.
// - After reset the RC oscillator is the source until software changes it.
// - Main oscillator is usable only after the wake-up timer confirms it.
// - RTC oscillator gives a 1 Hz tick and a clock output source.
// - Watchdog clock runs while the watchdog is on; it is a clock output.
// - Sleep stops only the core clock; any enabled interrupt resumes it.
// - In Sleep DMA keeps running; flash and main SRAM are disabled.
// - Deep-sleep stops all clocks except the watchdog clock and the RTC tick, and stops the main oscillator; keeps RC, RTC and flash power.
// - Entering Deep-sleep turns off the PLLs and zeroes all dividers except the PLL output dividers.
// - Deep-sleep ends on any enabled wake source.
// - Deep-sleep wake stalls 4 cycles on RC, 4096 on main oscillator.
`timescale 1ns/1ps
module clock_power_mode_control
#(
   parameter int unsigned RTC_TICKS = clk_pm_pkg::RTC_TICKS_DEF,
   parameter int unsigned OSC_STARTUP = clk_pm_pkg::OSC_STARTUP_DEF
)
(
   input logic clk_i, // System clock
   input logic rst_i, // Synchronous reset
   input logic wb_cyc_i, // Wishbone cycle
   input logic wb_stb_i, // Wishbone strobe
   input logic wb_we_i, // Wishbone write
   input logic [7:0] wb_adr_i, // Byte address
   input logic [3:0] wb_sel_i, // Byte lanes
   input logic [31:0] wb_dat_i, // Write data
   output logic [31:0] wb_dat_o, // Read data
   output logic wb_ack_o, // Acknowledge
   input logic irc_tick_i, // RC oscillator tick
   input logic osc_tick_i, // Main oscillator tick
   input logic main_cco_tick_i, // Main PLL oscillator tick
   input logic alt_cco_tick_i, // Alternate PLL oscillator tick
   input logic rtc_tick_i, // 32 kHz RTC oscillator tick
   input logic wdt_tick_i, // 500 kHz watchdog oscillator tick
   input logic wdt_enabled_i, // Watchdog running
   input logic irq_pending_i, // Enabled interrupt pending
   input logic [clk_pm_pkg::WAKE_W-1:0] wake_src_i, // Wake sources
   output logic cpu_clk_en_o, // Core clock pulse
   output logic [clk_pm_pkg::PER_N-1:0] per_clk_en_o, // Peripheral pulses
   output logic usb_clk_en_o, // USB clock pulse
   output logic clock_output_pin_o, // Clock output pin
   output logic rtc_1hz_o, // RTC 1 Hz tick
   output logic wdt_clk_en_o, // Watchdog clock pulse
   output logic dma_en_o, // DMA may run
   output logic flash_en_o, // Flash available
   output logic sram_en_o, // Main SRAM available
   output logic flash_pwr_o, // Flash powered
   output logic irc_out_en_o, // RC oscillator output on
   output logic irc_pwr_o, // RC oscillator powered
   output logic osc_run_o, // Main oscillator running
   output logic rtc_osc_run_o, // RTC oscillator running
   output logic main_pll_pwr_o, // Main PLL powered
   output logic alt_pll_pwr_o // Alternate PLL powered
);
   import clk_pm_pkg::*;

   function automatic div_step_type div_step(input logic tick,
      input logic [4:0] cnt, input logic [4:0] div);
      div_step_type r;
      r.pulse = 1'b0;
      r.cnt = cnt;
      if (div <= 5'h01)
      begin
         r.pulse = tick;
         r.cnt = 5'h00;
      end
      else if (tick)
      begin
         if (cnt == div - 5'h01)
         begin
            r.pulse = 1'b1;
            r.cnt = 5'h00;
         end
         else
            r.cnt = cnt + 5'h01;
      end
      return r;
   endfunction : div_step

   function automatic logic [4:0] min_two(input logic [3:0] d);
      logic [4:0] w;
      w = {1'b0, d};
      return (w < PLL_DIV_MIN) ? PLL_DIV_MIN : w;
   endfunction : min_two

   function automatic logic [3:0] reg_decode(input logic [7:0] adr);
      logic [3:0] r;
      if (adr == SRC_SEL_OFS) r = IDX_SRC;
      else if (adr == PLL_CTRL_OFS) r = IDX_PLL;
      else if (adr == DIV_CTRL_OFS) r = IDX_DIV;
      else if (adr == PER_DIV_OFS) r = IDX_PDIV;
      else if (adr == PER_GATE_OFS) r = IDX_GATE;
      else if (adr == OSC_CTRL_OFS) r = IDX_OSC;
      else if (adr == PWR_CTRL_OFS) r = IDX_PWR;
      else if (adr == STATUS_OFS) r = IDX_STAT;
      else r = IDX_NONE;
      return r;
   endfunction : reg_decode

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] val, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b]) r[8*b +: 8] = val[8*b +: 8];
      end
      return r;
   endfunction : merge

   pm_state_type state_ff, nxt_state;
   src_sel_type src_ff, nxt_src;
   pll_ctrl_type pll_ff, nxt_pll;
   div_ctrl_type div_ff, nxt_div;
   logic [PER_N-1:0][4:0] per_div_ff, nxt_per_div;
   logic [PER_N-1:0] per_gate_ff, nxt_per_gate;
   logic osc_en_ff, nxt_osc_en;
   logic [WAKE_W-1:0] wake_mask_ff, nxt_wake_mask;
   logic ack_ff, nxt_ack;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [12:0] stall_ff, nxt_stall;
   logic osc_used_ff, nxt_osc_used;
   logic osc_ok_ff, nxt_osc_ok;
   logic [12:0] osc_cnt_ff, nxt_osc_cnt;
   logic bus_req, bus_wr, sleep_req, deep_req, enter_deep, stall_done;
   logic [3:0] ridx;
   logic [31:0] rd_val, wval;

   // Register file and Wishbone slave
   always_comb
   begin
      ridx = reg_decode(wb_adr_i);
      bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
      bus_wr = bus_req & wb_we_i;
      if (ridx == IDX_SRC) rd_val = 32'(src_ff);
      else if (ridx == IDX_PLL) rd_val = 32'(pll_ff);
      else if (ridx == IDX_DIV) rd_val = 32'(div_ff);
      else if (ridx == IDX_PDIV) rd_val = 32'(per_div_ff);
      else if (ridx == IDX_GATE) rd_val = 32'(per_gate_ff);
      else if (ridx == IDX_OSC) rd_val = 32'(osc_en_ff);
      else if (ridx == IDX_PWR) rd_val = 32'(wake_mask_ff) << WAKE_POS;
      else if (ridx == IDX_STAT)
         rd_val = 32'({osc_used_ff, state_ff, pll_ff.alt_en,
                       pll_ff.main_en & pll_ff.main_conn, osc_ok_ff});
      else rd_val = 32'h0000_0000;
      wval = merge(rd_val, wb_dat_i, wb_sel_i);
      sleep_req = bus_wr & (ridx == IDX_PWR) & wval[PWR_SLEEP_BIT];
      deep_req = bus_wr & (ridx == IDX_PWR) & wval[PWR_DEEP_BIT];
      enter_deep = deep_req & (state_ff == ST_RUN);
      nxt_ack = bus_req;
      nxt_rdata = (bus_req & ~wb_we_i) ? rd_val : 32'h0000_0000;
      nxt_src = src_ff;
      nxt_pll = pll_ff;
      nxt_div = div_ff;
      nxt_per_div = per_div_ff;
      nxt_per_gate = per_gate_ff;
      nxt_osc_en = osc_en_ff;
      nxt_wake_mask = wake_mask_ff;
      if (bus_wr)
      begin
         if (ridx == IDX_SRC) nxt_src = src_sel_type'(wval[4:0]);
         else if (ridx == IDX_PLL) nxt_pll = pll_ctrl_type'(wval[10:0]);
         else if (ridx == IDX_DIV) nxt_div = div_ctrl_type'(wval[12:0]);
         else if (ridx == IDX_PDIV) nxt_per_div = wval[19:0];
         else if (ridx == IDX_GATE) nxt_per_gate = wval[PER_N-1:0];
         else if (ridx == IDX_OSC) nxt_osc_en = wval[OSC_EN_BIT];
         else if (ridx == IDX_PWR)
            nxt_wake_mask = wval[WAKE_POS +: WAKE_W];
      end
      if (enter_deep)
      begin
         nxt_pll.main_en = 1'b0;
         nxt_pll.main_conn = 1'b0;
         nxt_pll.alt_en = 1'b0;
         nxt_div = DIV_CTRL_RST;
         nxt_per_div = '0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         src_ff <= SRC_SEL_RST;
         pll_ff <= PLL_CTRL_RST;
         div_ff <= DIV_CTRL_RST;
         per_div_ff <= '0;
         per_gate_ff <= PER_GATE_RST;
         osc_en_ff <= 1'b0;
         wake_mask_ff <= '0;
         ack_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end
      else
      begin
         src_ff <= nxt_src;
         pll_ff <= nxt_pll;
         div_ff <= nxt_div;
         per_div_ff <= nxt_per_div;
         per_gate_ff <= nxt_per_gate;
         osc_en_ff <= nxt_osc_en;
         wake_mask_ff <= nxt_wake_mask;
         ack_ff <= nxt_ack;
         rdata_ff <= nxt_rdata;
      end
   end

   // Power mode sequencing and oscillator qualification
   always_comb
   begin
      nxt_state = state_ff;
      nxt_stall = stall_ff;
      nxt_osc_used = osc_used_ff;
      stall_done = (stall_ff == ((osc_used_ff ? OSC_STALL_CYC
                                              : IRC_STALL_CYC) - 13'h0001));
      case (state_ff)
         ST_RUN:
         begin
            if (enter_deep)
            begin
               nxt_state = ST_DEEP;
               nxt_osc_used = src_ff.ref_osc;
            end
            else if (sleep_req)
               nxt_state = ST_SLEEP;
         end
         ST_SLEEP:
         begin
            if (irq_pending_i) nxt_state = ST_RUN;
         end
         ST_DEEP:
         begin
            if (|(wake_src_i & wake_mask_ff))
            begin
               nxt_state = ST_STALL;
               nxt_stall = 13'h0000;
            end
         end
         default:
         begin
            if (stall_done) nxt_state = ST_RUN;
            else nxt_stall = stall_ff + 13'h0001;
         end
      endcase
      nxt_osc_ok = osc_ok_ff;
      nxt_osc_cnt = osc_cnt_ff;
      if (~osc_en_ff | (state_ff == ST_DEEP))
      begin
         nxt_osc_ok = 1'b0;
         nxt_osc_cnt = 13'h0000;
      end
      else if ((state_ff == ST_STALL) & osc_used_ff & stall_done)
         nxt_osc_ok = 1'b1;
      else if (~osc_ok_ff & osc_tick_i)
      begin
         if (osc_cnt_ff == 13'(OSC_STARTUP - 1)) nxt_osc_ok = 1'b1;
         else nxt_osc_cnt = osc_cnt_ff + 13'h0001;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_ff <= ST_RUN;
         stall_ff <= 13'h0000;
         osc_used_ff <= 1'b0;
         osc_ok_ff <= 1'b0;
         osc_cnt_ff <= 13'h0000;
      end
      else
      begin
         state_ff <= nxt_state;
         stall_ff <= nxt_stall;
         osc_used_ff <= nxt_osc_used;
         osc_ok_ff <= nxt_osc_ok;
         osc_cnt_ff <= nxt_osc_cnt;
      end
   end

   // Clock tree: sources, dividers (core and peripheral settings boundary-loaded), gates
   logic clocks_on, ref_tick, src_tick, out_tick, usb_tick;
   div_step_type mpll, apll, cpu, usb, cko;
   div_step_type [PER_N-1:0] per;
   logic [4:0] mcnt_ff, nxt_mcnt, acnt_ff, nxt_acnt, ccnt_ff, nxt_ccnt;
   logic [4:0] ucnt_ff, nxt_ucnt, ocnt_ff, nxt_ocnt;
   logic [4:0] cdiv_ff, nxt_cdiv;
   logic cpu_pll_ff, nxt_cpu_pll;
   logic [PER_N-1:0][4:0] pcnt_ff, nxt_pcnt, pdiv_ff, nxt_pdiv;
   logic [15:0] rtc_cnt_ff, nxt_rtc_cnt;
   logic cpu_en_ff, nxt_cpu_en, usb_en_ff, nxt_usb_en, clock_output_pin_ff;
   logic nxt_clock_output_pin, rtc_1hz_ff, nxt_rtc_1hz, wdt_en_ff, nxt_wdt_en;
   logic [PER_N-1:0] per_en_ff, nxt_per_en;
   logic [9:0] pwr_ff, nxt_pwr;

   always_comb
   begin
      clocks_on = (state_ff == ST_RUN) | (state_ff == ST_SLEEP);
      ref_tick = clocks_on & (src_ff.ref_osc ? (osc_tick_i & osc_ok_ff)
                                             : irc_tick_i);
      mpll = div_step(clocks_on & pll_ff.main_en & main_cco_tick_i,
                      mcnt_ff, min_two(pll_ff.main_div));
      apll = div_step(clocks_on & pll_ff.alt_en & osc_ok_ff
                      & alt_cco_tick_i, acnt_ff,
                      min_two(pll_ff.alt_div));
      src_tick = cpu_pll_ff ? mpll.pulse : ref_tick;
      cpu = div_step(src_tick, ccnt_ff, cdiv_ff);
      nxt_cpu_pll = cpu_pll_ff;
      nxt_cdiv = cdiv_ff;
      nxt_ccnt = cpu.cnt;
      if (~(pll_ff.main_en & pll_ff.main_conn))
      begin
         nxt_cpu_pll = 1'b0;
         if (cpu_pll_ff) nxt_ccnt = 5'h00;
      end
      if (nxt_ccnt == 5'h00)
      begin
         nxt_cpu_pll = pll_ff.main_en & pll_ff.main_conn
                       & src_ff.cpu_pll;
         nxt_cdiv = div_ff.cpu_div;
      end
      for (int i = 0; i < PER_N; i++)
      begin
         per[i] = div_step(src_tick & per_gate_ff[i], pcnt_ff[i],
                           pdiv_ff[i]);
         nxt_pcnt[i] = per[i].cnt;
         nxt_pdiv[i] = (per[i].cnt == 5'h00) ? per_div_ff[i]
                                             : pdiv_ff[i];
         nxt_per_en[i] = per[i].pulse & per_gate_ff[i];
      end
      usb_tick = (src_ff.usb_alt & pll_ff.alt_en) ? apll.pulse
                                                  : mpll.pulse;
      usb = div_step(usb_tick, ucnt_ff, {1'b0, div_ff.usb_div});
      case (src_ff.out_sel)
         OUT_CPU: out_tick = cpu.pulse;
         OUT_OSC: out_tick = clocks_on & osc_tick_i & osc_ok_ff;
         OUT_RTC: out_tick = rtc_tick_i;
         default: out_tick = wdt_tick_i & wdt_enabled_i;
      endcase
      cko = div_step(out_tick & clocks_on, ocnt_ff,
                     {1'b0, div_ff.out_div});
      nxt_clock_output_pin = clock_output_pin_ff ^ cko.pulse;
      nxt_rtc_1hz = 1'b0;
      nxt_rtc_cnt = rtc_cnt_ff;
      if (rtc_tick_i)
      begin
         if (rtc_cnt_ff == 16'(RTC_TICKS - 1))
         begin
            nxt_rtc_1hz = 1'b1;
            nxt_rtc_cnt = 16'h0000;
         end
         else
            nxt_rtc_cnt = rtc_cnt_ff + 16'h0001;
      end
      nxt_mcnt = mpll.cnt;
      nxt_acnt = apll.cnt;
      nxt_ucnt = usb.cnt;
      nxt_ocnt = cko.cnt;
      if (~clocks_on)
      begin
         nxt_mcnt = 5'h00;
         nxt_acnt = 5'h00;
         nxt_ccnt = 5'h00;
         nxt_ucnt = 5'h00;
         nxt_ocnt = 5'h00;
         nxt_pcnt = '0;
      end
      nxt_cpu_en = cpu.pulse & (state_ff == ST_RUN);
      nxt_usb_en = usb.pulse;
      nxt_wdt_en = wdt_tick_i & wdt_enabled_i;
      // dma, flash, sram, flash power, irc out, irc power, osc, rtc, plls
      nxt_pwr = {clocks_on, state_ff == ST_RUN, state_ff == ST_RUN, 1'b1,
                 state_ff != ST_DEEP, 1'b1,
                 osc_en_ff & (state_ff != ST_DEEP), 1'b1,
                 pll_ff.main_en, pll_ff.alt_en};
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mcnt_ff <= 5'h00;
         acnt_ff <= 5'h00;
         ccnt_ff <= 5'h00;
         ucnt_ff <= 5'h00;
         ocnt_ff <= 5'h00;
         cdiv_ff <= 5'h00;
         cpu_pll_ff <= 1'b0;
         pcnt_ff <= '0;
         pdiv_ff <= '0;
         rtc_cnt_ff <= 16'h0000;
         cpu_en_ff <= 1'b0;
         per_en_ff <= '0;
         usb_en_ff <= 1'b0;
         clock_output_pin_ff <= 1'b0;
         rtc_1hz_ff <= 1'b0;
         wdt_en_ff <= 1'b0;
         pwr_ff <= 10'h000;
      end
      else
      begin
         mcnt_ff <= nxt_mcnt;
         acnt_ff <= nxt_acnt;
         ccnt_ff <= nxt_ccnt;
         ucnt_ff <= nxt_ucnt;
         ocnt_ff <= nxt_ocnt;
         cdiv_ff <= nxt_cdiv;
         cpu_pll_ff <= nxt_cpu_pll;
         pcnt_ff <= nxt_pcnt;
         pdiv_ff <= nxt_pdiv;
         rtc_cnt_ff <= nxt_rtc_cnt;
         cpu_en_ff <= nxt_cpu_en;
         per_en_ff <= nxt_per_en;
         usb_en_ff <= nxt_usb_en;
         clock_output_pin_ff <= nxt_clock_output_pin;
         rtc_1hz_ff <= nxt_rtc_1hz;
         wdt_en_ff <= nxt_wdt_en;
         pwr_ff <= nxt_pwr;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdata_ff;
   assign cpu_clk_en_o = cpu_en_ff;
   assign per_clk_en_o = per_en_ff;
   assign usb_clk_en_o = usb_en_ff;
   assign clock_output_pin_o = clock_output_pin_ff;
   assign rtc_1hz_o = rtc_1hz_ff;
   assign wdt_clk_en_o = wdt_en_ff;
   assign {dma_en_o, flash_en_o, sram_en_o, flash_pwr_o, irc_out_en_o,
           irc_pwr_o, osc_run_o, rtc_osc_run_o, main_pll_pwr_o,
           alt_pll_pwr_o} = pwr_ff;

   // Checks
   logic [12:0] stall_len_ff;
   always_ff @(posedge clk_i)
   begin
      if (rst_i) stall_len_ff <= 13'h0000;
      else if (state_ff == ST_STALL) stall_len_ff <= stall_len_ff + 13'h0001;
      else stall_len_ff <= 13'h0000;
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   pll_reset_off_a: assert property ($fell(rst_i) |->
      !main_pll_pwr_o && !alt_pll_pwr_o && !cpu_pll_ff)
      else $error("PLL powered right after reset");
   ref_osc_gate_a: assert property (src_ff.ref_osc && !osc_ok_ff
      && !cpu_pll_ff |=> !cpu_clk_en_o)
      else $error("Unqualified main oscillator used as reference");
   cpu_src_pll_a: assert property (!(pll_ff.main_en && pll_ff.main_conn)
      |=> !cpu_pll_ff)
      else $error("Core fed from PLL that is not active and connected");
   pll_div_min_a: assert property (mpll.pulse |=> !mpll.pulse)
      else $error("Main PLL divider below two");
   per_gate_off_a: assert property (!per_gate_ff[0] |=>
      !per_clk_en_o[0])
      else $error("Gated peripheral still clocked");
   sleep_core_a: assert property (state_ff == ST_SLEEP |=>
      !cpu_clk_en_o)
      else $error("Core clock running in Sleep");
   sleep_mem_a: assert property (state_ff == ST_SLEEP |=>
      dma_en_o && !flash_en_o && !sram_en_o)
      else $error("Sleep memory enables wrong");
   deep_clocks_a: assert property (state_ff == ST_DEEP ##1
      state_ff == ST_DEEP |-> !osc_run_o && !irc_out_en_o && irc_pwr_o
      && flash_pwr_o && rtc_osc_run_o && per_clk_en_o == '0
      && !cpu_clk_en_o)
      else $error("Deep-sleep clock or power state wrong");
   deep_clear_a: assert property (state_ff == ST_RUN
      && nxt_state == ST_DEEP |=> !pll_ff.main_en && !pll_ff.alt_en
      && div_ff == DIV_CTRL_RST && per_div_ff == '0)
      else $error("Deep-sleep entry did not clear PLL and dividers");
   deep_wake_a: assert property (state_ff == ST_DEEP
      && |(wake_src_i & wake_mask_ff) |=> state_ff == ST_STALL)
      else $error("Enabled wake source ignored");
   irc_stall_a: assert property ($rose(state_ff == ST_STALL)
      && !osc_used_ff |-> (state_ff == ST_STALL)[*4] ##1 state_ff == ST_RUN)
      else $error("RC wake stall not four cycles");
   stall_len_a: assert property ($fell(state_ff == ST_STALL) |->
      stall_len_ff == (osc_used_ff ? OSC_STALL_CYC : IRC_STALL_CYC))
      else $error("Wake stall length does not match recorded source");
   wb_ack_pulse_a: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("Wishbone ack not a single-cycle answer");

   sleep_wake_c: cover property (state_ff == ST_SLEEP ##1
      state_ff == ST_RUN);
   deep_osc_c: cover property ($fell(state_ff == ST_STALL) && osc_used_ff);
   pll_core_c: cover property (cpu_pll_ff && cpu_clk_en_o);
   clock_output_pin_rtc_c: cover property (src_ff.out_sel == OUT_RTC
      && $changed(clock_output_pin_o));
endmodule : clock_power_mode_control

// ### sim/osc_model.sv
`timescale 1ns/1ps
module osc_model
(
   input wire logic clk_i, // System clock
   output logic [5:0] tick_o // rc, osc, main cco, alt cco, rtc, wdt
);
   logic [7:0] cnt_ff = 8'h00;
   always @(posedge clk_i)
   begin
      cnt_ff <= cnt_ff + 8'h01;
   end
   // Oscillators tick every 4 (rc), 2 (osc, alt cco), 1 (main cco), 8 (rtc) and 16 (wdt) cycles
   assign tick_o = {cnt_ff[1:0] == 2'h0, cnt_ff[0], 1'b1, cnt_ff[0],
                    cnt_ff[2:0] == 3'h0, cnt_ff[3:0] == 4'h0};
endmodule : osc_model

// ### sim/clock_power_mode_control_tb_top.sv
`timescale 1ns/1ps
module clock_power_mode_control_tb_top;
   import clk_pm_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, wdt_on = 1'b0, irq = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000, rdat, dat_o, v;
   logic ack, cpu_en, dma_en, flash_en, irc_out, rtc_hz, wdt_en, mpll_pwr;
   logic [3:0] per_en;
   logic [5:0] obs;
   logic [WAKE_W-1:0] wake = '0;
   logic [5:0] tk;
   int err_total = 0, compares = 0, cyc_n = 0;
   int cnt [6];
   always #12.5 clk_i = ~clk_i;
   osc_model osc (.clk_i(clk_i), .tick_o(tk));
   clock_power_mode_control #(.RTC_TICKS(8), .OSC_STARTUP(4)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .irc_tick_i(tk[5]),
      .osc_tick_i(tk[4]), .main_cco_tick_i(tk[3]), .alt_cco_tick_i(tk[2]),
      .rtc_tick_i(tk[1]), .wdt_tick_i(tk[0]), .wdt_enabled_i(wdt_on),
      .irq_pending_i(irq), .wake_src_i(wake), .cpu_clk_en_o(cpu_en),
      .per_clk_en_o(per_en), .usb_clk_en_o(), .clock_output_pin_o(),
      .rtc_1hz_o(rtc_hz), .wdt_clk_en_o(wdt_en), .dma_en_o(dma_en),
      .flash_en_o(flash_en), .sram_en_o(), .flash_pwr_o(),
      .irc_out_en_o(irc_out), .irc_pwr_o(), .osc_run_o(),
      .rtc_osc_run_o(), .main_pll_pwr_o(mpll_pwr), .alt_pll_pwr_o());
   assign obs = {mpll_pwr, wdt_en, rtc_hz, per_en[1:0], cpu_en};
   function automatic int exp_pulses(input int len, input int per);
      return len / per;
   endfunction : exp_pulses
   function automatic logic [31:0] exp_div(input logic [31:0] d);
      return d & 32'h0000_1FFF;
   endfunction : exp_div
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finish_test
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] s);
      compares++;
      if (s !== e)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // One classic cycle; only the bench timeout ends the wait for ack
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do
      begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus
   // Enter Deep-sleep, wake it and read the stall state
   task automatic deep_wake(input logic [31:0] e);
      bus(1'b1, PWR_CTRL_OFS, 32'h0001_0002);
      repeat (2) @(posedge clk_i);
      chk("irc out", 32'h0000_0000, {31'h0, irc_out});
      wake <= 12'h001;
      bus(1'b0, STATUS_OFS, 32'h0000_0000);
      chk("stall", e, (rdat >> 3) & 32'h7);
      wake <= 12'h000;
   endtask : deep_wake
   // Counts pulses of each observed output over len cycles
   task automatic tally(input int len);
      for (int i = 0; i < 6; i++)
         cnt[i] = 0;
      repeat (len)
      begin
         @(posedge clk_i);
         for (int i = 0; i < 6; i++)
            if (obs[i] === 1'b1)
               cnt[i]++;
      end
   endtask : tally
   always @(posedge clk_i)
   begin
      cyc_n++;
      if (cyc_n == 6000)
      begin
         err_total++;
         finish_test();
      end
   end
   initial
   begin
      v = $urandom(489);
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, PER_GATE_OFS, 32'h0000_0000);
      chk("gate", 32'h0000_000F, rdat);
      bus(1'b0, SRC_SEL_OFS, 32'h0000_0000);
      chk("srcsel", 32'h0000_0000, rdat);
      bus(1'b0, PLL_CTRL_OFS, 32'h0000_0000);
      chk("pll", 32'h0000_0000, rdat);
      bus(1'b0, 8'h40, 32'h0000_0000);
      chk("unmapped", 32'h0000_0000, rdat);
      repeat (4)
      begin
         v = $urandom;
         bus(1'b1, DIV_CTRL_OFS, v);
         bus(1'b0, DIV_CTRL_OFS, 32'h0000_0000);
         chk("div", exp_div(v), rdat);
      end
      bus(1'b1, PLL_CTRL_OFS, 32'h0000_0003);
      @(posedge clk_i);
      chk("pll pwr", 32'h0000_0001, {31'h0, mpll_pwr});
      deep_wake(32'h0000_0003);
      repeat (4) @(posedge clk_i);
      bus(1'b0, STATUS_OFS, 32'h0000_0000);
      chk("run", 32'h0000_0000, (rdat >> 3) & 32'h3);
      bus(1'b0, DIV_CTRL_OFS, 32'h0000_0000);
      chk("div clr", 32'h0000_0000, rdat);
      bus(1'b0, PLL_CTRL_OFS, 32'h0000_0000);
      chk("pll clr", 32'h0000_0000, rdat);
      bus(1'b1, PWR_CTRL_OFS, 32'h0000_0001);
      repeat (2) @(posedge clk_i);
      chk("flash", 32'h0000_0000, {31'h0, flash_en});
      chk("dma", 32'h0000_0001, {31'h0, dma_en});
      tally(16);
      chk("cpu stop", 32'h0000_0000, cnt[0]);
      irq <= 1'b1;
      tally(16);
      irq <= 1'b0;
      chk("cpu run", 32'h0000_0001, {31'h0, cnt[0] > 0});
      wdt_on <= 1'b1;
      bus(1'b1, SRC_SEL_OFS, 32'h0000_0001);
      tally(16);
      chk("cpu gated", 32'h0000_0000, cnt[0]);
      bus(1'b1, SRC_SEL_OFS, 32'h0000_0000);
      bus(1'b1, PER_GATE_OFS, 32'h0000_000E);
      tally(128);
      chk("cpu", exp_pulses(128, 4), cnt[0]);
      chk("per off", 32'h0000_0000, cnt[1]);
      chk("per on", exp_pulses(128, 4), cnt[2]);
      chk("rtc 1hz", exp_pulses(128, 64), cnt[3]);
      chk("wdt", exp_pulses(128, 16), cnt[4]);
      chk("pll off", 32'h0000_0000, cnt[5]);
      bus(1'b1, OSC_CTRL_OFS, 32'h0000_0001);
      repeat (16) @(posedge clk_i);
      bus(1'b1, SRC_SEL_OFS, 32'h0000_0001);
      deep_wake(32'h0000_0007);
      repeat (4000) @(posedge clk_i);
      bus(1'b0, STATUS_OFS, 32'h0000_0000);
      chk("osc stall", 32'h0000_0003, (rdat >> 3) & 32'h3);
      repeat (100) @(posedge clk_i);
      bus(1'b0, STATUS_OFS, 32'h0000_0000);
      chk("osc run", 32'h0000_0000, (rdat >> 3) & 32'h3);
      finish_test();
   end
endmodule : clock_power_mode_control_tb_top
